// [dax_pkg.sv]
package dax_pkg;

   // Register map, byte addresses on the APB slave.
   localparam logic [11:0] DAX_AUTOBUF_CTRL_OFFS = 12'h000;
   localparam logic [11:0] DAX_INT_MASK_OFFS     = 12'h004;
   localparam logic [11:0] DAX_INT_STATUS_OFFS   = 12'h008;
   localparam logic [11:0] DAX_ALU_RESULT_OFFS   = 12'h00c;
   localparam logic [11:0] DAX_ALU_FEEDBACK_OFFS = 12'h010;
   localparam logic [11:0] DAX_ALU_FLAGS_OFFS    = 12'h014;
   localparam logic [11:0] DAX_MAC_LOW_OFFS      = 12'h018;
   localparam logic [11:0] DAX_MAC_MID_OFFS      = 12'h01c;
   localparam logic [11:0] DAX_MAC_HIGH_OFFS     = 12'h020;

   // Field positions and reset values.
   localparam int          DAX_BIAS_BIT          = 12;
   localparam logic [15:0] DAX_AUTOBUF_RST       = 16'h0000;
   localparam logic [15:0] DAX_INT_MASK_RST      = 16'h0000;
   localparam logic        DAX_GIE_RST           = 1'b1;
   localparam logic [15:0] DAX_HALF_CODE         = 16'h8000;

   // ALU function codes.
   typedef enum logic [3:0]
   {
      DAX_FN_ADD    = 4'h0,
      DAX_FN_ADDC   = 4'h1,
      DAX_FN_SUBXY  = 4'h2,
      DAX_FN_SUBXYB = 4'h3,
      DAX_FN_SUBYX  = 4'h4,
      DAX_FN_SUBYXB = 4'h5,
      DAX_FN_AND    = 4'h6,
      DAX_FN_OR     = 4'h7,
      DAX_FN_XOR    = 4'h8,
      DAX_FN_PASSY  = 4'h9,
      DAX_FN_PASSX  = 4'ha,
      DAX_FN_NEGY   = 4'hb,
      DAX_FN_NOTX   = 4'hc,
      DAX_FN_ABSX   = 4'hd,
      DAX_FN_DIVIDE_SIGN_STEP   = 4'he,
      DAX_FN_DIVIDE_QUOTIENT_STEP   = 4'hf
   } dax_alu_fn_type;

   // MAC operations.
   typedef enum logic [1:0]
   {
      DAX_MAC_MUL = 2'b00,
      DAX_MAC_ADD = 2'b01,
      DAX_MAC_SUB = 2'b10,
      DAX_MAC_RND = 2'b11
   } dax_mac_op_type;

endpackage

// [dax_alu_mac.sv]
`timescale 1ns/10ps
// Summary of operation
// - A result-free ALU operation updates the flags but leaves the result and feedback registers alone.
// - Result-free form takes only unconditional base ALU operations, never divide steps or constants.
// - The MAC can use the X operand as the Y operand too, for squaring and sum of squares.
// - The rounding bias select bit picks unbiased rounding at 0 and biased rounding at 1.
// - In biased mode a low word of exactly 0x8000 always rounds up.
// - In unbiased mode a halfway low word rounds up only when the middle word is odd.
// - Both modes round the same whenever the low word is not the halfway code.
// - The rounding bias select sits at bit twelve of the serial port zero autobuffer control.
// - Global interrupt enable is set after reset.
// - The enable instruction resumes servicing of every unmasked interrupt, except when a disable instruction arrives in the same cycle, which wins.
// - The disable instruction blocks all servicing except autobuffer transfers, without touching the source mask register.
// - Autobuffer transfers run whether global interrupts are enabled or not.
// - The global disable also blocks the powerdown interrupt.
module dax_alu_mac
   import dax_pkg::*;
#(
   parameter int NUM_IRQ = 8
)
(
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [11:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   input  wire logic                 alu_valid_i,
   input  wire logic                 alu_result_free_i,
   input  wire logic                 alu_cond_true_i,
   input  wire logic                 alu_to_feedback_i,
   input  wire logic                 alu_use_const_i,
   input  wire dax_alu_fn_type       alu_fn_i,
   input  wire logic [15:0]          alu_x_i,
   input  wire logic [15:0]          alu_y_i,
   output logic                      alu_illegal_o,
   input  wire logic                 mac_valid_i,
   input  wire logic                 mac_cond_true_i,
   input  wire logic                 mac_square_i,
   input  wire logic                 mac_uu_i,
   input  wire dax_mac_op_type       mac_op_i,
   input  wire logic [15:0]          mac_x_i,
   input  wire logic [15:0]          mac_y_i,
   input  wire logic                 global_interrupt_enable_instr_i,
   input  wire logic                 global_interrupt_disable_instr_i,
   input  wire logic [NUM_IRQ-1:0]   irq_pending_i,
   input  wire logic                 powerdown_req_i,
   input  wire logic                 autobuf_req_i,
   output logic      [NUM_IRQ-1:0]   irq_service_o,
   output logic                      powerdown_service_o,
   output logic                      autobuf_service_o,
   output logic      [15:0]          alu_result_o,
   output logic      [39:0]          mac_result_o
);

   logic [15:0] autobuf_ctrl_reg;
   logic [15:0] interrupt_source_mask_register_reg;
   logic        gie_reg;
   logic [15:0] alu_result_register_reg;
   logic [15:0] alu_feedback_register_reg;
   logic [3:0]  alu_flags_reg;
   logic [39:0] mac_result_register_reg;
   logic        rounding_bias_select;
   logic        apb_wr;
   logic        apb_rd;
   logic        mask_wr;

   // The bus answers in the access cycle itself, so pready is always high.
   assign pready_o  = 1'b1;
   assign apb_wr    = psel_i & penable_i & pwrite_i;
   assign apb_rd    = psel_i & ~pwrite_i;
   assign mask_wr   = apb_wr & (paddr_i == DAX_INT_MASK_OFFS);
   assign rounding_bias_select = autobuf_ctrl_reg[DAX_BIAS_BIT];

   // Software-written control registers.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         autobuf_ctrl_reg                   <= DAX_AUTOBUF_RST;
         interrupt_source_mask_register_reg <= DAX_INT_MASK_RST;
      end
      else if (apb_wr)
      begin
         if (paddr_i == DAX_AUTOBUF_CTRL_OFFS)
            autobuf_ctrl_reg <= pwdata_i[15:0];
         if (paddr_i == DAX_INT_MASK_OFFS)
            interrupt_source_mask_register_reg <= pwdata_i[15:0];
      end
   end

   // Read mux; unmapped addresses read zero and report an error.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         prdata_o <= 32'h0000_0000;
      end
      else if (apb_rd && !penable_i)
      begin
         unique case (paddr_i)
            DAX_AUTOBUF_CTRL_OFFS: prdata_o <= {16'h0000, autobuf_ctrl_reg};
            DAX_INT_MASK_OFFS:     prdata_o <= {16'h0000, interrupt_source_mask_register_reg};
            DAX_INT_STATUS_OFFS:   prdata_o <= {31'h0000_0000, gie_reg};
            DAX_ALU_RESULT_OFFS:   prdata_o <= {16'h0000, alu_result_register_reg};
            DAX_ALU_FEEDBACK_OFFS: prdata_o <= {16'h0000, alu_feedback_register_reg};
            DAX_ALU_FLAGS_OFFS:    prdata_o <= {28'h000_0000, alu_flags_reg};
            DAX_MAC_LOW_OFFS:      prdata_o <= {16'h0000, mac_result_register_reg[15:0]};
            DAX_MAC_MID_OFFS:      prdata_o <= {16'h0000, mac_result_register_reg[31:16]};
            DAX_MAC_HIGH_OFFS:     prdata_o <= {24'h00_0000, mac_result_register_reg[39:32]};
            default:               prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // Error flag is valid in the access cycle.
   always_comb
   begin
      pslverr_o = 1'b0;
      if (psel_i && penable_i && paddr_i > DAX_MAC_HIGH_OFFS)
         pslverr_o = 1'b1;
      if (psel_i && penable_i && paddr_i[1:0] != 2'b00)
         pslverr_o = 1'b1;
   end

   // ALU compute; flags are zero, negative, carry, overflow.
   logic [16:0] alu_sum;
   logic [15:0] alu_val;
   logic        alu_ovf;
   logic        alu_do;
   logic        alu_illegal;
   always_comb
   begin
      alu_sum = 17'h0_0000;
      alu_ovf = 1'b0;
      unique case (alu_fn_i)
         DAX_FN_ADD:    alu_sum = {1'b0, alu_x_i} + {1'b0, alu_y_i};
         DAX_FN_ADDC:   alu_sum = {1'b0, alu_x_i} + {1'b0, alu_y_i} + {16'h0000, alu_flags_reg[1]};
         DAX_FN_SUBXY:  alu_sum = {1'b0, alu_x_i} + {1'b0, ~alu_y_i} + 17'h0_0001;
         DAX_FN_SUBXYB: alu_sum = {1'b0, alu_x_i} + {1'b0, ~alu_y_i} + {16'h0000, alu_flags_reg[1]};
         DAX_FN_SUBYX:  alu_sum = {1'b0, alu_y_i} + {1'b0, ~alu_x_i} + 17'h0_0001;
         DAX_FN_SUBYXB: alu_sum = {1'b0, alu_y_i} + {1'b0, ~alu_x_i} + {16'h0000, alu_flags_reg[1]};
         DAX_FN_AND:    alu_sum = {1'b0, alu_x_i & alu_y_i};
         DAX_FN_OR:     alu_sum = {1'b0, alu_x_i | alu_y_i};
         DAX_FN_XOR:    alu_sum = {1'b0, alu_x_i ^ alu_y_i};
         DAX_FN_PASSY:  alu_sum = {1'b0, alu_y_i};
         DAX_FN_PASSX:  alu_sum = {1'b0, alu_x_i};
         DAX_FN_NEGY:   alu_sum = {1'b0, ~alu_y_i} + 17'h0_0001;
         DAX_FN_NOTX:   alu_sum = {1'b0, ~alu_x_i};
         DAX_FN_ABSX:   alu_sum = alu_x_i[15] ? ({1'b0, ~alu_x_i} + 17'h0_0001) : {1'b0, alu_x_i};
         default:       alu_sum = {1'b0, alu_x_i};
      endcase
      alu_val = alu_sum[15:0];
      if (alu_fn_i inside {DAX_FN_ADD, DAX_FN_ADDC})
         alu_ovf = (alu_x_i[15] == alu_y_i[15]) && (alu_val[15] != alu_x_i[15]);
   end

   // Result-free form refuses conditions, divide steps and extended constants.
   assign alu_illegal = alu_result_free_i & (~alu_cond_true_i | alu_use_const_i
                        | alu_fn_i == DAX_FN_DIVIDE_SIGN_STEP | alu_fn_i == DAX_FN_DIVIDE_QUOTIENT_STEP);
   assign alu_do      = alu_valid_i & alu_cond_true_i & ~alu_illegal;

   // ALU registers; a result-free op writes flags only.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         alu_result_register_reg   <= 16'h0000;
         alu_feedback_register_reg <= 16'h0000;
         alu_flags_reg             <= 4'h0;
         alu_illegal_o             <= 1'b0;
      end
      else
      begin
         alu_illegal_o <= alu_valid_i & alu_illegal;
         if (alu_do)
         begin
            alu_flags_reg <= {alu_val == 16'h0000, alu_val[15], alu_sum[16], alu_ovf};
            if (!alu_result_free_i && alu_to_feedback_i)
               alu_feedback_register_reg <= alu_val;
            else if (!alu_result_free_i)
               alu_result_register_reg <= alu_val;
         end
      end
   end

   // Multiplier; squaring feeds the X operand to both inputs.
   logic [15:0] mul_y;
   logic [39:0] product;
   logic [39:0] mac_next;
   logic        low_half;
   logic [31:0] prod_ss;
   assign mul_y    = mac_square_i ? mac_x_i : mac_y_i;
   // Both factors are sign-extended first so the full 32-bit product survives.
   assign prod_ss  = $signed({{16{mac_x_i[15]}}, mac_x_i}) * $signed({{16{mul_y[15]}}, mul_y});
   assign low_half = mac_result_register_reg[15:0] == DAX_HALF_CODE;
   always_comb
   begin
      if (mac_uu_i)
         product = {8'h00, {16'h0000, mac_x_i} * {16'h0000, mul_y}};
      else
         product = {{8{prod_ss[31]}}, prod_ss};
      mac_next = mac_result_register_reg;
      unique case (mac_op_i)
         DAX_MAC_MUL: mac_next = product;
         DAX_MAC_ADD: mac_next = mac_result_register_reg + product;
         DAX_MAC_SUB: mac_next = mac_result_register_reg - product;
         DAX_MAC_RND:
         begin
            mac_next = mac_result_register_reg + {24'h00_0000, DAX_HALF_CODE};
            if (low_half && !rounding_bias_select)
               mac_next[16] = 1'b0;
         end
      endcase
   end

   // MAC result register, loaded on a true conditional op.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         mac_result_register_reg <= 40'h00_0000_0000;
      else if (mac_valid_i && mac_cond_true_i)
         mac_result_register_reg <= mac_next;
   end

   // Global interrupt enable; the instructions never touch the mask register.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         gie_reg <= DAX_GIE_RST;
      else if (global_interrupt_disable_instr_i)
         gie_reg <= 1'b0;
      else if (global_interrupt_enable_instr_i)
         gie_reg <= 1'b1;
   end

   // Service gating; autobuffer bypasses the global enable deliberately.
   assign irq_service_o       = irq_pending_i & interrupt_source_mask_register_reg[NUM_IRQ-1:0]
                                & {NUM_IRQ{gie_reg}};
   assign powerdown_service_o = powerdown_req_i & gie_reg;
   assign autobuf_service_o   = autobuf_req_i;
   assign alu_result_o        = alu_result_register_reg;
   assign mac_result_o        = mac_result_register_reg;

   property p_result_free_keeps;
      @(posedge clk_i) disable iff (!nrst_i)
      alu_valid_i && alu_result_free_i |=> $stable(alu_result_register_reg)
         && $stable(alu_feedback_register_reg);
   endproperty
   a_result_free_keeps: assert property (p_result_free_keeps)
      else $error("Result-free op changed a result register.");

   property p_illegal_flagged;
      @(posedge clk_i) disable iff (!nrst_i)
      alu_valid_i && alu_result_free_i && (alu_fn_i == DAX_FN_DIVIDE_SIGN_STEP) |=> alu_illegal_o
         && $stable(alu_flags_reg);
   endproperty
   a_illegal_flagged: assert property (p_illegal_flagged)
      else $error("Divide step in result-free form was not refused.");

   property p_square;
      @(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_cond_true_i && mac_square_i && mac_op_i == DAX_MAC_MUL && mac_uu_i
         |=> mac_result_register_reg
         == {8'h00, {16'h0000, $past(mac_x_i)} * {16'h0000, $past(mac_x_i)}};
   endproperty
   a_square: assert property (p_square)
      else $error("Square result wrong.");

   property p_biased_up;
      @(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_cond_true_i && mac_op_i == DAX_MAC_RND && low_half
         && rounding_bias_select |=> mac_result_register_reg[31:16]
         == $past(mac_result_register_reg[31:16]) + 16'h0001;
   endproperty
   a_biased_up: assert property (p_biased_up)
      else $error("Biased halfway rounding did not round up.");

   property p_unbiased_even;
      @(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_cond_true_i && mac_op_i == DAX_MAC_RND && low_half
         && !rounding_bias_select |=> mac_result_register_reg[16] == 1'b0;
   endproperty
   a_unbiased_even: assert property (p_unbiased_even)
      else $error("Unbiased halfway rounding left an odd middle word.");

   property p_non_half_same;
      @(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_cond_true_i && mac_op_i == DAX_MAC_RND && !low_half
         |=> mac_result_register_reg == $past(mac_result_register_reg) + 40'h00_0000_8000;
   endproperty
   a_non_half_same: assert property (p_non_half_same)
      else $error("Non-halfway rounding differs from plain add.");

   property p_disable_blocks;
      @(posedge clk_i) disable iff (!nrst_i)
      global_interrupt_disable_instr_i |=> (irq_service_o == '0) && !powerdown_service_o
         && ($stable(interrupt_source_mask_register_reg) || $past(mask_wr));
   endproperty
   a_disable_blocks: assert property (p_disable_blocks)
      else $error("Interrupt serviced after global disable.");

   property p_enable_resumes;
      @(posedge clk_i) disable iff (!nrst_i)
      global_interrupt_enable_instr_i && !global_interrupt_disable_instr_i |=> irq_service_o
         == (irq_pending_i & interrupt_source_mask_register_reg[NUM_IRQ-1:0]);
   endproperty
   a_enable_resumes: assert property (p_enable_resumes)
      else $error("Unmasked interrupt not serviced after enable.");

   property p_autobuf;
      @(posedge clk_i) disable iff (!nrst_i)
      autobuf_req_i && !gie_reg |-> autobuf_service_o;
   endproperty
   a_autobuf: assert property (p_autobuf)
      else $error("Autobuffer blocked by global disable.");

   property p_const_refused;
      @(posedge clk_i) disable iff (!nrst_i)
      alu_valid_i && alu_result_free_i && alu_use_const_i |=> alu_illegal_o
         && $stable(alu_flags_reg) && $stable(alu_result_register_reg);
   endproperty
   a_const_refused: assert property (p_const_refused)
      else $error("Constant operation in result-free form was not refused.");

   property p_powerdown_gated;
      @(posedge clk_i) disable iff (!nrst_i)
      powerdown_req_i && !gie_reg |-> !powerdown_service_o;
   endproperty
   a_powerdown_gated: assert property (p_powerdown_gated)
      else $error("Powerdown interrupt serviced while globally disabled.");

   c_square_acc: cover property (@(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_square_i && mac_op_i == DAX_MAC_ADD);
   c_biased_half: cover property (@(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_op_i == DAX_MAC_RND && low_half && rounding_bias_select);
   c_result_free: cover property (@(posedge clk_i) disable iff (!nrst_i)
      alu_do && alu_result_free_i);
   c_dis_en: cover property (@(posedge clk_i) disable iff (!nrst_i)
      global_interrupt_disable_instr_i ##[1:20] global_interrupt_enable_instr_i);
   c_unbiased_half: cover property (@(posedge clk_i) disable iff (!nrst_i)
      mac_valid_i && mac_op_i == DAX_MAC_RND && low_half && !rounding_bias_select);

endmodule

// [test_dsp_alu_mac_extensions.sv]
`timescale 1ns/10ps
module test_dsp_alu_mac_extensions;
   import dax_pkg::*;

   // Stimulus and observed signals; every input gets a value at time zero.
   logic                 clk_i = 1'b0;
   logic                 nrst_i = 1'b0;
   logic                 psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [11:0]          paddr_i;
   logic [31:0]          pwdata_i, prdata_o;
   logic                 alu_valid_i, alu_result_free_i, alu_cond_true_i;
   logic                 alu_to_feedback_i, alu_use_const_i, alu_illegal_o;
   dax_alu_fn_type       alu_fn_i;
   logic [15:0]          alu_x_i, alu_y_i, mac_x_i, mac_y_i, alu_result_o;
   logic                 mac_valid_i, mac_cond_true_i, mac_square_i, mac_uu_i;
   dax_mac_op_type       mac_op_i;
   logic                 ena_i, dis_i, powerdown_req_i, autobuf_req_i;
   logic                 powerdown_service_o, autobuf_service_o;
   logic [7:0]           irq_pending_i, irq_service_o;
   logic [39:0]          mac_result_o;
   int                   err_count, checks_done, cycles;

   // A 50 MHz clock.
   always #10 clk_i = ~clk_i;

   dax_alu_mac #(.NUM_IRQ(8)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .alu_valid_i(alu_valid_i), .alu_result_free_i(alu_result_free_i),
      .alu_cond_true_i(alu_cond_true_i), .alu_to_feedback_i(alu_to_feedback_i),
      .alu_use_const_i(alu_use_const_i), .alu_fn_i(alu_fn_i), .alu_x_i(alu_x_i),
      .alu_y_i(alu_y_i), .alu_illegal_o(alu_illegal_o), .mac_valid_i(mac_valid_i),
      .mac_cond_true_i(mac_cond_true_i), .mac_square_i(mac_square_i), .mac_uu_i(mac_uu_i),
      .mac_op_i(mac_op_i), .mac_x_i(mac_x_i), .mac_y_i(mac_y_i),
      .global_interrupt_enable_instr_i(ena_i), .global_interrupt_disable_instr_i(dis_i),
      .irq_pending_i(irq_pending_i), .powerdown_req_i(powerdown_req_i),
      .autobuf_req_i(autobuf_req_i), .irq_service_o(irq_service_o),
      .powerdown_service_o(powerdown_service_o), .autobuf_service_o(autobuf_service_o),
      .alu_result_o(alu_result_o), .mac_result_o(mac_result_o));

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Cuts a hang short; the whole run needs well under a thousand cycles.
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         tally_and_finish;
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= addr;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic apb_chk(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                          input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic        er;
      apb(wr, addr, wd, rd, er);
      if (!wr)
         chk(rd, exp, "read data");
      chk(er, experr, "slave error");
   endtask

   // Instructions are one-cycle pulses; checks run 1 ns after the taking edge.
   task automatic alu_do(input logic rf, cnd, fb, cst, input dax_alu_fn_type fn,
                         input logic [15:0] x, y);
      @(posedge clk_i);
      alu_valid_i <= 1'b1;
      alu_result_free_i <= rf;
      alu_cond_true_i <= cnd;
      alu_to_feedback_i <= fb;
      alu_use_const_i <= cst;
      alu_fn_i <= fn;
      alu_x_i <= x;
      alu_y_i <= y;
      @(posedge clk_i);
      alu_valid_i <= 1'b0;
      #1;
   endtask

   task automatic mac_do(input logic cnd, sq, input dax_mac_op_type op,
                         input logic [15:0] x, y);
      @(posedge clk_i);
      mac_valid_i <= 1'b1;
      mac_cond_true_i <= cnd;
      mac_square_i <= sq;
      mac_op_i <= op;
      mac_x_i <= x;
      mac_y_i <= y;
      @(posedge clk_i);
      mac_valid_i <= 1'b0;
      #1;
   endtask

   task automatic gie_pulse(input logic en, dis);
      @(posedge clk_i);
      ena_i <= en;
      dis_i <= dis;
      @(posedge clk_i);
      ena_i <= 1'b0;
      dis_i <= 1'b0;
      #1;
   endtask

   task automatic t_regs;
      apb_chk(1'b0, DAX_AUTOBUF_CTRL_OFFS, 32'h0, 32'h0, 1'b0);
      apb_chk(1'b0, DAX_INT_MASK_OFFS, 32'h0, 32'h0, 1'b0);
      apb_chk(1'b0, DAX_INT_STATUS_OFFS, 32'h0, 32'h1, 1'b0);
      apb_chk(1'b1, DAX_AUTOBUF_CTRL_OFFS, 32'h1 << DAX_BIAS_BIT, 32'h0, 1'b0);
      apb_chk(1'b0, DAX_AUTOBUF_CTRL_OFFS, 32'h0, 32'h1 << DAX_BIAS_BIT, 1'b0);
      apb_chk(1'b1, DAX_ALU_RESULT_OFFS, 32'hffff, 32'h0, 1'b0);
      apb_chk(1'b0, DAX_ALU_RESULT_OFFS, 32'h0, 32'h0, 1'b0);
      apb_chk(1'b1, 12'h024, 32'hffff, 32'h0, 1'b1);
      apb_chk(1'b0, 12'h024, 32'h0, 32'h0, 1'b1);
      apb_chk(1'b0, 12'h002, 32'h0, 32'h0, 1'b1);
   endtask

   // Result-free forms must leave both destinations alone yet move the zero flag.
   task automatic t_alu;
      logic [31:0] rd;
      logic        er;
      dax_alu_fn_type bad_fn[3] = '{DAX_FN_DIVIDE_SIGN_STEP, DAX_FN_DIVIDE_QUOTIENT_STEP, DAX_FN_ADD};
      alu_do(1'b0, 1'b1, 1'b0, 1'b0, DAX_FN_ADD, 16'h0001, 16'h0002);
      chk(alu_result_o, 40'h3, "alu result");
      alu_do(1'b0, 1'b1, 1'b1, 1'b0, DAX_FN_ADD, 16'h0007, 16'h0001);
      apb_chk(1'b0, DAX_ALU_FEEDBACK_OFFS, 32'h0, 32'h8, 1'b0);
      alu_do(1'b1, 1'b1, 1'b0, 1'b0, DAX_FN_SUBXY, 16'h0005, 16'h0005);
      chk(alu_result_o, 40'h3, "result after result-free");
      apb(1'b0, DAX_ALU_FLAGS_OFFS, 32'h0, rd, er);
      chk(rd[3], 1'b1, "zero flag set");
      alu_do(1'b1, 1'b1, 1'b0, 1'b0, DAX_FN_XOR, 16'h0005, 16'h0004);
      apb(1'b0, DAX_ALU_FLAGS_OFFS, 32'h0, rd, er);
      chk(rd[3], 1'b0, "zero flag clear");
      apb_chk(1'b0, DAX_ALU_FEEDBACK_OFFS, 32'h0, 32'h8, 1'b0);
      apb_chk(1'b0, DAX_ALU_RESULT_OFFS, 32'h0, 32'h3, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         alu_do(1'b1, 1'b1, 1'b0, i == 2, bad_fn[i], 16'h0009, 16'h0009);
         chk(alu_illegal_o, 1'b1, "illegal pulse");
         @(posedge clk_i);
         #1;
         chk(alu_illegal_o, 1'b0, "illegal pulse length");
         chk(alu_result_o, 40'h3, "result after illegal");
      end
   endtask

   task automatic t_square;
      mac_do(1'b1, 1'b1, DAX_MAC_MUL, 16'h0003, 16'h0005);
      chk(mac_result_o, 40'd9, "square");
      mac_do(1'b1, 1'b1, DAX_MAC_ADD, 16'h0004, 16'h0007);
      chk(mac_result_o, 40'd25, "sum of squares");
      mac_do(1'b0, 1'b1, DAX_MAC_ADD, 16'h0009, 16'h0009);
      chk(mac_result_o, 40'd25, "false condition");
      mac_do(1'b1, 1'b1, DAX_MAC_SUB, 16'h0003, 16'h0008);
      chk(mac_result_o, 40'd16, "square subtract");
      @(posedge clk_i);
      mac_uu_i <= 1'b0;
      mac_do(1'b1, 1'b1, DAX_MAC_MUL, 16'hffff, 16'h0002);
      chk(mac_result_o, 40'd1, "signed square");
      mac_do(1'b1, 1'b0, DAX_MAC_MUL, 16'hfffe, 16'h0003);
      chk(mac_result_o, 40'hff_ffff_fffa, "signed product");
      @(posedge clk_i);
      mac_uu_i <= 1'b1;
   endtask

   // Products land on and around the halfway code with odd and even middle words.
   task automatic t_round;
      logic [15:0] xs[6] = '{16'h1, 16'h3, 16'h5, 16'h1, 16'h1, 16'h3};
      logic [15:0] ys[6] = '{16'h8000, 16'h8000, 16'h8000, 16'h8001, 16'h7fff, 16'h7fff};
      logic [39:0] v, e;
      for (int b = 0; b < 2; b++)
         for (int i = 0; i < 6; i++)
         begin
            apb_chk(1'b1, DAX_AUTOBUF_CTRL_OFFS, 32'(b) << DAX_BIAS_BIT, 32'h0, 1'b0);
            v = {24'h0, xs[i]} * {24'h0, ys[i]};
            e = v + 40'h8000;
            if (b == 0 && v[15:0] == DAX_HALF_CODE)
               e[16] = 1'b0;
            mac_do(1'b1, 1'b0, DAX_MAC_MUL, xs[i], ys[i]);
            chk(mac_result_o, v, "product");
            mac_do(1'b1, 1'b0, DAX_MAC_RND, 16'h0, 16'h0);
            chk(mac_result_o[39:16], e[39:16], "rounded");
         end
   endtask

   task automatic t_irq;
      @(posedge clk_i);
      irq_pending_i <= 8'hff;
      powerdown_req_i <= 1'b1;
      autobuf_req_i <= 1'b1;
      apb_chk(1'b1, DAX_INT_MASK_OFFS, 32'h5a, 32'h0, 1'b0);
      #1;
      chk(irq_service_o, 8'h5a, "service after reset");
      gie_pulse(1'b0, 1'b1);
      chk(irq_service_o, 8'h00, "service when disabled");
      chk(powerdown_service_o, 1'b0, "powerdown when disabled");
      chk(autobuf_service_o, 1'b1, "autobuffer when disabled");
      apb_chk(1'b0, DAX_INT_MASK_OFFS, 32'h0, 32'h5a, 1'b0);
      apb_chk(1'b0, DAX_INT_STATUS_OFFS, 32'h0, 32'h0, 1'b0);
      gie_pulse(1'b1, 1'b0);
      chk(irq_service_o, 8'h5a, "service re-enabled");
      chk(powerdown_service_o, 1'b1, "powerdown re-enabled");
      gie_pulse(1'b1, 1'b1);
      chk(irq_service_o, 8'h00, "both pulses");
      chk(autobuf_service_o, 1'b1, "autobuffer both pulses");
   endtask

   // Unsigned products keep the halfway cases free of sign extension.
   initial
   begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {alu_valid_i, alu_result_free_i, alu_cond_true_i, alu_to_feedback_i} = '0;
      {alu_use_const_i, alu_x_i, alu_y_i, mac_valid_i, mac_cond_true_i} = '0;
      {mac_square_i, mac_x_i, mac_y_i, ena_i, dis_i, irq_pending_i} = '0;
      {powerdown_req_i, autobuf_req_i, err_count, checks_done, cycles} = '0;
      alu_fn_i = DAX_FN_ADD;
      mac_op_i = DAX_MAC_MUL;
      mac_uu_i = 1'b1;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_regs;
      t_alu;
      t_square;
      t_round;
      t_irq;
      tally_and_finish;
   end
endmodule
